// ### verilog/imd_unit.sv
// Unsigned 8x8 multiply and 16/8 divide unit with result flags
// Behaviour
// - Unsigned unit: 8x8 product or 16/8 quotient and remainder, three flags.
// - Multiply: multiplier in source, multiplicand in low byte, mode 0 starts.
// - Ten cycles after start, product loads high and low destination bytes.
// - Flags update in the same cycle the result is loaded.
// - Multiply: negative flag is high destination byte MSB.
// - Multiply: overflow flag always cleared.
// - Multiply: zero flag set only when whole 16-bit product is zero.
// - Divide: divisor in source, dividend in both bytes, mode 1 starts.
// - Ten cycles after start, quotient to low byte, remainder to high byte.
// - Quotient wider than 8 bits leaves both destination bytes unchanged.
// - Divide: negative flag is low quotient byte MSB (kept low byte MSB for a zero divisor).
// - Divide: overflow set when quotient exceeds 8 bits or the divisor is zero, else cleared.
// - Divide: zero flag set only when low quotient byte is zero (kept low byte for a zero divisor).
// - Dividend high byte is whatever the high destination register holds.
// - Source register keeps its value until software writes it again.
// - Multiply ignores the high destination byte.
// - Mode readback is one while running, zero when stopped.
`timescale 1ns/1ps
module imd_unit (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // CPU write port
  input wire imd_pkg::imd_wr_s wr_i,
  // Register contents
  output logic [7:0] source_operand_o,
  output logic [7:0] dest_low_byte_o,
  output logic [7:0] dest_high_byte_o,
  // Status
  output imd_pkg::imd_flags_s flags_o,
  output logic calc_mode_start_o
);

  // Start write taken at edge 0, busy from then on
  // Result, flags and busy drop land ten edges later
  // Two clocks per bus cycle, hence the five bus cycle wait

  // Sequencer state and operands captured at the start write
  imd_pkg::imd_state_e state_ff, nxt_state;
  logic [3:0] cnt_ff, nxt_cnt;
  logic mode_ff, nxt_mode;
  logic [7:0] src_ff, nxt_src;
  logic [7:0] dlo_ff, nxt_dlo;
  logic [7:0] dhi_ff, nxt_dhi;
  logic [7:0] op_src_ff, nxt_op_src;
  logic [15:0] op_dst_ff, nxt_op_dst;
  imd_pkg::imd_flags_s flags_ff, nxt_flags;
  logic busy_ff, nxt_busy;

  // Combinational results of the captured operands
  logic [15:0] product;
  logic [15:0] quotient;
  logic [7:0] remainder;
  logic div_ovf;
  logic [7:0] div_flag_byte; // Byte the divide flags look at
  logic done;

  // Arithmetic on operands captured at the start write
  always_comb
  begin
    // Both factors widened first so no product bit is lost
    product = {8'h00, op_dst_ff[7:0]} * {8'h00, op_src_ff};
    // Quotient too wide exactly when the high byte reaches the divisor
    div_ovf = (op_src_ff == imd_pkg::BYTE_RST) || (op_dst_ff[15:8] >= op_src_ff);
    if (op_src_ff == imd_pkg::BYTE_RST)
    begin
      // Zero divisor: no quotient, flags follow the kept low byte
      quotient = 16'h0000;
      remainder = imd_pkg::BYTE_RST;
      div_flag_byte = op_dst_ff[7:0];
    end
    else
    begin
      quotient = op_dst_ff / {8'h00, op_src_ff};
      remainder = 8'(op_dst_ff % {8'h00, op_src_ff});
      // Flags see the low quotient byte even when it is not loaded
      div_flag_byte = quotient[7:0];
    end
  end

  // Last run cycle: counter at its final count
  // Start edge counts as cycle 0, so the load is ten edges on
  assign done = (state_ff == imd_pkg::IMD_RUN) && (cnt_ff == imd_pkg::OP_CYCLES_M1);

  // Sequencer and operand capture
  always_comb
  begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    nxt_mode = mode_ff;
    nxt_op_src = op_src_ff;
    nxt_op_dst = op_dst_ff;
    case (state_ff)
      imd_pkg::IMD_IDLE:
      begin
        // Start only from idle; a start write while running is dropped
        if (wr_i.mode_we)
        begin
          nxt_state = imd_pkg::IMD_RUN;
          nxt_cnt = imd_pkg::CNT_RST;
          nxt_mode = wr_i.data[0];
          // Operands frozen here; later byte writes feed the next run
          nxt_op_src = src_ff;
          nxt_op_dst = {dhi_ff, dlo_ff};
        end
      end
      imd_pkg::IMD_RUN:
      begin
        nxt_cnt = 4'(cnt_ff + 4'h1);
        if (done)
        begin
          nxt_state = imd_pkg::IMD_IDLE;
        end
      end
      default:
      begin
        nxt_state = imd_pkg::IMD_IDLE;
      end
    endcase
    // Busy follows the next state so its flop tracks the run exactly
    nxt_busy = (nxt_state == imd_pkg::IMD_RUN);
  end

  // Register file, result load and flags
  always_comb
  begin
    nxt_src = src_ff;
    nxt_dlo = dlo_ff;
    nxt_dhi = dhi_ff;
    nxt_flags = flags_ff;
    // CPU byte writes land whenever strobed, even while running
    if (wr_i.src_we)
    begin
      nxt_src = wr_i.data;
    end
    if (wr_i.dlo_we)
    begin
      nxt_dlo = wr_i.data;
    end
    if (wr_i.dhi_we)
    begin
      nxt_dhi = wr_i.data;
    end
    // Result load wins over a CPU write in the same cycle
    // A destination byte written in the load cycle is lost; software waits first
    if (done && (mode_ff == imd_pkg::MODE_MUL))
    begin
      nxt_dhi = product[15:8];
      nxt_dlo = product[7:0];
      nxt_flags.negative_flag = product[15];
      nxt_flags.overflow_flag = 1'b0;
      nxt_flags.zero_flag = (product == 16'h0000);
    end
    else if (done)
    begin
      // Overflow puts the captured dividend back in place
      if (!div_ovf)
      begin
        nxt_dlo = quotient[7:0];
        nxt_dhi = remainder;
      end
      else
      begin
        nxt_dlo = op_dst_ff[7:0];
        nxt_dhi = op_dst_ff[15:8];
      end
      nxt_flags.negative_flag = div_flag_byte[7];
      nxt_flags.overflow_flag = div_ovf;
      nxt_flags.zero_flag = (div_flag_byte == imd_pkg::BYTE_RST);
    end
  end

  // Sequencer registers
  // Known reset values instead of undefined power-up contents
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      state_ff <= imd_pkg::IMD_IDLE;
      cnt_ff <= imd_pkg::CNT_RST;
      mode_ff <= imd_pkg::MODE_MUL;
      op_src_ff <= imd_pkg::BYTE_RST;
      op_dst_ff <= 16'h0000;
      busy_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      mode_ff <= nxt_mode;
      op_src_ff <= nxt_op_src;
      op_dst_ff <= nxt_op_dst;
      busy_ff <= nxt_busy;
    end
  end

  // Register file and flag registers
  always_ff @(posedge clk_i)
  begin
    if (reset_i)
    begin
      src_ff <= imd_pkg::BYTE_RST;
      dlo_ff <= imd_pkg::BYTE_RST;
      dhi_ff <= imd_pkg::BYTE_RST;
      flags_ff <= '0;
    end
    else
    begin
      src_ff <= nxt_src;
      dlo_ff <= nxt_dlo;
      dhi_ff <= nxt_dhi;
      flags_ff <= nxt_flags;
    end
  end

  // Outputs straight from flops
  // No logic after the flops, so the CPU reads settled values
  assign source_operand_o = src_ff;
  assign dest_low_byte_o = dlo_ff;
  assign dest_high_byte_o = dhi_ff;
  assign flags_o = flags_ff;
  assign calc_mode_start_o = busy_ff;

endmodule

// ### verilog/imd_pkg.sv
// Package for the unsigned integer multiply/divide unit
package imd_pkg;
  // Cycles from the start write to the result load
  localparam int unsigned OP_CYCLES = 10;
  localparam logic [3:0] OP_CYCLES_M1 = 4'(OP_CYCLES - 1);
  // Calculation mode encodings
  localparam logic MODE_MUL = 1'b0;
  localparam logic MODE_DIV = 1'b1;
  // Reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] CNT_RST = 4'h0;

  typedef enum logic {IMD_IDLE, IMD_RUN} imd_state_e;

  // Write strobes from the CPU side, one byte of data
  typedef struct packed {
    logic src_we;
    logic dlo_we;
    logic dhi_we;
    logic mode_we;
    logic [7:0] data;
  } imd_wr_s;

  // Result flags
  typedef struct packed {
    logic negative_flag;
    logic overflow_flag;
    logic zero_flag;
  } imd_flags_s;
endpackage

// ### bench/imd_cpu.sv
// CPU side write model for the multiply/divide unit
`timescale 1ns/1ps
module imd_cpu (
  // Clock
  input wire logic clk_i,
  // Write port toward the unit
  output imd_pkg::imd_wr_s wr_o
);
  initial wr_o = '0;
  // One-cycle strobe: 0 source, 1 low, 2 high, 3 mode
  task automatic put(input int k, input logic [7:0] v);
    @(posedge clk_i);
    wr_o <= {4'(1 << (3 - k)), v};
    @(posedge clk_i);
    wr_o <= '0;
  endtask
  // Wait out the operation before any read
  task automatic fin();
    repeat (11) @(posedge clk_i);
    #1;
  endtask
  // Load operands, start, wait
  task automatic run(input logic [7:0] s, lo, hi, input logic m);
    put(0, s);
    put(1, lo);
    put(2, hi);
    put(3, {7'h00, m});
    fin();
  endtask
endmodule

// ### bench/imd_unit_chk.sv
// Port assertions for the multiply/divide unit
`timescale 1ns/1ps
module imd_unit_chk (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_i,
  // Watched ports
  input wire imd_pkg::imd_wr_s wr_i,
  input wire logic [7:0] source_operand_o,
  input wire logic [7:0] dest_low_byte_o,
  input wire logic [7:0] dest_high_byte_o,
  input wire imd_pkg::imd_flags_s flags_o,
  input wire logic calc_mode_start_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (reset_i);
  // Short views and accepted starts
  wire logic [7:0] s = source_operand_o;
  wire logic [7:0] dh = dest_high_byte_o;
  wire logic [7:0] dl = dest_low_byte_o;
  wire logic [15:0] d = {dh, dl};
  wire logic [7:0] q = 8'(d / {8'h00, s});
  wire logic b = calc_mode_start_o;
  wire logic mul = wr_i.mode_we && !b && !wr_i.data[0];
  wire logic dv = wr_i.mode_we && !b && wr_i.data[0];
  busy_len_a: assert property ((mul || dv) |=> b [*8] ##1 b [*2] ##1 !b)
    else $error("busy span wrong");
  mul_prod_a: assert property (mul |-> ##11 d == $past(s, 11) * $past(dl, 11))
    else $error("product wrong");
  mul_flags_a: assert property (mul |-> ##11 flags_o == {dh[7], 1'b0, d == 16'h0000})
    else $error("multiply flags wrong");
  div_res_a: assert property (dv && dh < s |-> ##11
    d == {8'($past(d, 11) % $past(s, 11)), 8'($past(d, 11) / $past(s, 11))})
    else $error("quotient wrong");
  div_keep_a: assert property (dv && dh >= s |-> ##11 d == $past(d, 11))
    else $error("dividend not kept");
  div_ovf_a: assert property (dv |-> ##11
    flags_o.overflow_flag == ($past(dh, 11) >= $past(s, 11)))
    else $error("overflow flag wrong");
  div_flags_a: assert property (dv && (dh < s || s == 8'h00) |-> ##11
    flags_o.negative_flag == dl[7] && flags_o.zero_flag == (dl == 8'h00))
    else $error("divide flags wrong");
  div_qflag_a: assert property (dv && dh >= s && s != 8'h00 |-> ##11
    flags_o.negative_flag == $past(q[7], 11) && flags_o.zero_flag == ($past(q, 11) == 8'h00))
    else $error("overflow divide flags wrong");
  src_keep_a: assert property (!wr_i.src_we |=> $stable(s))
    else $error("source changed");
  flag_load_a: assert property ($changed(flags_o) |-> $past(b) && !b)
    else $error("flags moved off load");
endmodule

// ### bench/imd_unit_test.sv
// Self-checking bench for the multiply/divide unit
`timescale 1ns/1ps
module imd_unit_test;
  logic clk_i = 1'b0;
  logic reset_i = 1'b1;
  imd_pkg::imd_wr_s wr;
  logic [7:0] src, dlo, dhi;
  imd_pkg::imd_flags_s flg;
  logic busy;
  int fails = 0;
  int checks_done = 0;
  wire logic [27:0] seen = {src, dhi, dlo, flg, busy};
  // Clock, CPU model and unit
  always #2.5 clk_i = ~clk_i;
  imd_cpu u_cpu (.clk_i, .wr_o(wr));
  imd_unit i_dut (.clk_i, .reset_i, .wr_i(wr), .source_operand_o(src), .dest_low_byte_o(dlo),
    .dest_high_byte_o(dhi), .flags_o(flg), .calc_mode_start_o(busy));
  // Compare results, flags and busy
  task automatic chk(input string n, input logic [27:0] e);
    checks_done++;
    if (seen !== e)
    begin
      fails++;
      $display("[ERR] %s expected %h seen %h", n, e, seen);
    end
  endtask
  task automatic op(input logic [7:0] s, lo, hi, input logic m, input logic [15:0] r, input logic [2:0] f);
    u_cpu.run(s, lo, hi, m);
    chk("result", {s, r, f, 1'b0});
  endtask
  task automatic t_mul();
    #1;
    chk("reset", 28'h0000000);
    op(8'h64, 8'h00, 8'hFF, 1'b0, 16'h0000, 3'b001);
    op(8'h58, 8'h64, 8'hFF, 1'b0, 16'h2260, 3'b000);
    op(8'h58, 8'hC8, 8'h00, 1'b0, 16'h44C0, 3'b000);
    op(8'hA5, 8'hC8, 8'h00, 1'b0, 16'h80E8, 3'b100);
    $display("mul done");
  endtask
  task automatic t_div();
    op(8'h64, 8'h16, 8'h1A, 1'b1, 16'h4E42, 3'b000);
    op(8'h64, 8'h2C, 8'h33, 1'b1, 16'h0083, 3'b100);
    op(8'h58, 8'h00, 8'h00, 1'b1, 16'h0000, 3'b001);
    op(8'h13, 8'h68, 8'h24, 1'b1, 16'h2468, 3'b110);
    op(8'h00, 8'h80, 8'h12, 1'b1, 16'h1280, 3'b110);
    $display("div done");
  endtask
  task automatic t_chain();
    op(8'h13, 8'h24, 8'h00, 1'b1, 16'h1101, 3'b000);
    u_cpu.put(1, 8'h68);
    u_cpu.put(3, 8'h01);
    u_cpu.fin();
    chk("chain", {8'h13, 16'h0AEA, 3'b100, 1'b0});
    $display("chain done");
  endtask
  task automatic t_busy();
    u_cpu.put(0, 8'h03);
    u_cpu.put(1, 8'h05);
    u_cpu.put(3, 8'h00);
    #1;
    chk("busy", 28'h030A059);
    u_cpu.put(3, 8'h01);
    u_cpu.fin();
    chk("refuse", 28'h03000F0);
    $display("busy done");
  endtask
  task automatic results();
    $display("checks_done=%0d fails=%0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Reset then scenarios
  initial
  begin
    repeat (8) @(posedge clk_i);
    reset_i <= 1'b0;
    t_mul();
    t_div();
    t_chain();
    t_busy();
    results();
  end
  // Watchdog for a hung run
  initial
  begin
    #20000;
    fails++;
    results();
  end
endmodule
bind imd_unit imd_unit_chk i_chk (.clk_i, .reset_i, .wr_i, .source_operand_o, .dest_low_byte_o,
  .dest_high_byte_o, .flags_o, .calc_mode_start_o);
